/* File: rtl/ssp_pkg.sv */
// package for the synchronous slave serial port: register map, fields, resets
package ssp_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFF_TX_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_RX_CTRL = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_TX_HOLD = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_RX_BUF = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 6'h18;
  // tx_status_ctrl fields
  localparam int unsigned TXC_NINTH_BIT = 0;
  localparam int unsigned TXC_SHIFT_EMPTY = 1;
  localparam int unsigned TXC_SYNC_SEL = 4;
  localparam int unsigned TXC_TX_EN = 5;
  localparam int unsigned TXC_NINE_EN = 6;
  localparam int unsigned TXC_CLK_SRC = 7;
  // rx_status_ctrl fields
  localparam int unsigned RXC_NINTH_BIT = 0;
  localparam int unsigned RXC_OVERRUN = 1;
  localparam int unsigned RXC_CONT_EN = 4;
  localparam int unsigned RXC_SINGLE_EN = 5;
  localparam int unsigned RXC_NINE_EN = 6;
  localparam int unsigned RXC_PORT_EN = 7;
  // interrupt bits
  localparam int unsigned IRQ_TX_READY = 0;
  localparam int unsigned IRQ_RX_FULL = 1;
  localparam int unsigned IRQ_W = 2;
  localparam logic [7:0] TX_CTRL_RST = 8'h02;
  localparam logic [7:0] RX_CTRL_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned SYNC_STAGES = 2;
endpackage : ssp_pkg

/* File: rtl/ssp_pin_sync.sv */
// two-stage synchroniser with edge detection for pins from outside the clock
`timescale 1ns/1ps
module ssp_pin_sync #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
  } ssp_sync_t;
  ssp_sync_t s_q;
  ssp_sync_t s_d;
  always_comb begin
    s_d = s_q;
    s_d.meta = pin_i;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign level_o = s_q.sync;
  assign rise_o = s_q.sync & ~s_q.prev;
endmodule : ssp_pin_sync

/* File: rtl/ssp_core.sv */
// synchronous slave serial port with axi4-lite registers and interrupt
//
// Overview of operation
// - slave transmit and receive behave as master mode apart from sleep behaviour.
// - first written word moves to tx_shift_reg at once, shifts on external clocks.
// - second word waits in holding register, flag clear, until first word finishes.
// - tx_ready_flag rise with tx_irq_en raises the wake interrupt output.
// - clearing port_enable or tx_enable aborts transmit and resets its logic.
// - single_rx_en has no effect on reception in slave mode.
// - continuous receive accepts a word, moves it to buffer, sets rx_full_flag.
// - rx_full_flag with rx_irq_en raises the wake interrupt output.
// - status supplies ninth bit and errors; read status then 8-bit buffer.
// - clearing continuous_rx_en clears the reception error condition.
// - clearing port_enable or continuous_rx_en aborts reception and resets it.
// - slave mode is chosen by clearing clock_source_sel, bit 7 of tx control.
`timescale 1ns/1ps
module ssp_core (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [ssp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ssp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic shift_clock_pin_i,
  input wire logic data_pin_i,
  output logic data_pin_o,
  output logic data_pin_oe_o,
  output logic irq_o
);
  import ssp_pkg::*;

  typedef struct packed {
    logic [7:0] tx_ctrl;
    logic [7:0] rx_ctrl;
    logic [7:0] tx_holding_reg;
    logic hold_full;
    logic hold_ninth;
    logic [8:0] tx_shift_reg;
    logic [3:0] tx_cnt;
    logic tx_busy;
    logic [8:0] rx_shift_reg;
    logic [3:0] rx_cnt;
    logic [7:0] rx_buffer_reg;
    logic rx_ninth;
    logic rx_full;
    logic overrun;
    logic tx_irq_st;
    logic rx_irq_st;
    logic [IRQ_W-1:0] irq_en;
    logic data_out;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ssp_state_t;

  ssp_state_t q;
  ssp_state_t d;

  logic [1:0] pin_level;
  logic [1:0] pin_rise;
  logic clk_rise;
  logic clk_fall;
  logic clk_prev_q;

  // shift clock and data pin cross into the core clock before anything sees them
  ssp_pin_sync #(.WIDTH(2)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .pin_i({data_pin_i, shift_clock_pin_i}),
    .level_o(pin_level),
    .rise_o(pin_rise)
  );

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= pin_level[0];
    end
  end
  // both edges come from the synchronised level, so one cycle never shows both
  assign clk_rise = pin_rise[0];
  assign clk_fall = clk_prev_q & ~pin_level[0];

  logic port_en;
  logic slave_mode;
  logic tx_run;
  logic rx_run;
  logic nine_tx;
  logic nine_rx;
  logic [3:0] tx_bits;
  logic [3:0] rx_bits;
  logic tx_done;
  logic rx_done;
  logic tx_load;
  logic rx_land;
  logic rd_buf;
  logic wr_fire;
  logic rd_fire;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [7:0] rd_byte;
  logic rd_ok;
  logic wr_ok;

  always_comb begin
    port_en = q.tx_ctrl[TXC_SYNC_SEL] & q.rx_ctrl[RXC_PORT_EN];
    slave_mode = ~q.tx_ctrl[TXC_CLK_SRC];
    tx_run = port_en & slave_mode & q.tx_ctrl[TXC_TX_EN];
    // single_rx_en deliberately not a term here
    rx_run = port_en & slave_mode & q.rx_ctrl[RXC_CONT_EN];
    nine_tx = q.tx_ctrl[TXC_NINE_EN];
    nine_rx = q.rx_ctrl[RXC_NINE_EN];
    tx_bits = nine_tx ? 4'h9 : 4'h8;
    rx_bits = nine_rx ? 4'h9 : 4'h8;
    // the fall after the last bit ends the word, so a full frame needs no extra clock
    tx_done = q.tx_busy & clk_fall & ((q.tx_cnt + 4'h1) == tx_bits);
    rx_done = rx_run & clk_rise & ((q.rx_cnt + 4'h1) == rx_bits);
    // a word written with port_en set but before tx_enable waits and starts on the first enabled cycle
    tx_load = q.hold_full & ~q.tx_busy & tx_run;
    // a word that finds the buffer still full is dropped and flagged as overrun
    rx_land = rx_done & ~q.rx_full;
    wr_fire = (q.aw_got | s_axi_awvalid) & (q.w_got | s_axi_wvalid)
      & ~q.bvalid;
    rd_fire = s_axi_arvalid & ~q.rvalid;
    rd_buf = rd_fire & (s_axi_araddr == OFF_RX_BUF);
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{(q.w_got ? q.w_strb[i] : s_axi_wstrb[i])}};
    end
    wval = q.w_got ? q.w_data : s_axi_wdata;
  end

  always_comb begin
    logic [ADDR_W-1:0] wa;
    logic [7:0] wb;
    d = q;
    wa = q.aw_got ? q.aw_addr : s_axi_awaddr;
    wb = wval[7:0];
    wr_ok = 1'b1;
    rd_ok = 1'b1;
    rd_byte = 8'h00;

    // axi write channel capture, either order
    // nothing is captured while a response waits, as the ready outputs say
    if (s_axi_awvalid && !q.aw_got && !q.bvalid && !wr_fire) begin
      d.aw_got = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_got && !q.bvalid && !wr_fire) begin
      d.w_got = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // transmit: load shift register from holding register when idle
    if (tx_load) begin
      d.tx_shift_reg = {q.hold_ninth, q.tx_holding_reg};
      d.tx_busy = 1'b1;
      d.tx_cnt = 4'h0;
      d.hold_full = 1'b0;
      d.tx_irq_st = 1'b1;
      d.data_out = q.tx_holding_reg[0];
    end else if (q.tx_busy && clk_fall) begin
      // data changes on the falling shift clock edge, like master mode
      if (tx_done) begin
        d.tx_busy = 1'b0;
      end else begin
        // bit 0 went out at load, so each fall presents the next bit
        d.data_out = q.tx_shift_reg[1];
        d.tx_shift_reg = {1'b0, q.tx_shift_reg[8:1]};
        d.tx_cnt = q.tx_cnt + 4'h1;
      end
    end
    if (!tx_run) begin
      d.tx_busy = 1'b0;
      d.tx_cnt = 4'h0;
      d.data_out = 1'b0;
    end

    // receive: sample data on the rising shift clock edge
    if (rx_run && clk_rise) begin
      d.rx_shift_reg = {pin_level[1], q.rx_shift_reg[8:1]};
      d.rx_cnt = q.rx_cnt + 4'h1;
      if (rx_done) begin
        d.rx_cnt = 4'h0;
        if (!rx_land) begin
          d.overrun = 1'b1;
        end else begin
          d.rx_buffer_reg = nine_rx ? q.rx_shift_reg[8:1]
            : {pin_level[1], q.rx_shift_reg[8:2]};
          d.rx_ninth = nine_rx ? pin_level[1] : 1'b0;
          d.rx_full = 1'b1;
          d.rx_irq_st = 1'b1;
        end
      end
    end
    // a cut frame leaves no partial bits behind for the next word
    if (!rx_run) begin
      d.rx_cnt = 4'h0;
      d.rx_shift_reg = '0;
    end
    if (!q.rx_ctrl[RXC_CONT_EN]) begin
      d.overrun = 1'b0;
    end

    // register write
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      unique case (wa)
        OFF_TX_CTRL: begin
          if (wmask[0]) begin
            d.tx_ctrl = {wb[7:2], q.tx_ctrl[TXC_SHIFT_EMPTY], wb[0]};
          end
        end
        OFF_RX_CTRL: begin
          if (wmask[0]) begin
            d.rx_ctrl = {wb[7:4], 4'h0};
          end
        end
        OFF_TX_HOLD: begin
          if (wmask[0]) begin
            d.tx_holding_reg = wb;
            d.hold_full = 1'b1;
            d.hold_ninth = q.tx_ctrl[TXC_NINTH_BIT];
            // a pending word means the holding register is not empty any more
            d.tx_irq_st = 1'b0;
          end
        end
        OFF_IRQ_EN: begin
          if (wmask[0]) begin
            d.irq_en = wb[IRQ_W-1:0];
          end
        end
        OFF_IRQ_CLR: begin
          // a status event in the same cycle wins over the clear
          if (wmask[0] && wb[IRQ_TX_READY] && !tx_load) begin
            d.tx_irq_st = 1'b0;
          end
          if (wmask[0] && wb[IRQ_RX_FULL] && !rx_land) begin
            d.rx_irq_st = 1'b0;
          end
        end
        OFF_RX_BUF: begin
          wr_ok = 1'b0;
        end
        OFF_IRQ_STAT: begin
          wr_ok = 1'b0;
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
      d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // register read
    if (rd_fire) begin
      unique case (s_axi_araddr)
        OFF_TX_CTRL: rd_byte = {q.tx_ctrl[7:2], ~q.tx_busy & ~q.hold_full, q.tx_ctrl[0]};
        OFF_RX_CTRL: rd_byte = {q.rx_ctrl[7:4], 2'h0, q.overrun, q.rx_ninth};
        OFF_TX_HOLD: rd_byte = q.tx_holding_reg;
        OFF_RX_BUF: rd_byte = q.rx_buffer_reg;
        OFF_IRQ_STAT: rd_byte = {6'h00, q.rx_irq_st, q.tx_irq_st};
        OFF_IRQ_EN: rd_byte = {6'h00, q.irq_en};
        OFF_IRQ_CLR: rd_byte = 8'h00;
        default: rd_ok = 1'b0;
      endcase
      // reading the buffer empties it
      if (rd_buf) begin
        d.rx_full = d.rx_full & ~q.rx_full;
        if (!rx_land) begin
          d.rx_irq_st = 1'b0;
        end
      end
      d.rvalid = 1'b1;
      d.rdata = {24'h000000, rd_byte};
      d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // losing port_en clears a pending holding word too, so the restart is clean
    if (!port_en) begin
      d.hold_full = q.hold_full & tx_run;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
      q.tx_ctrl <= TX_CTRL_RST;
      q.rx_ctrl <= RX_CTRL_RST;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = ~q.aw_got & ~q.bvalid;
  assign s_axi_wready = ~q.w_got & ~q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = ~q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign data_pin_o = q.data_out;
  assign data_pin_oe_o = tx_run;
  // status bits are sticky; the level output follows enabled bits that are set
  assign irq_o = (q.irq_en[IRQ_TX_READY] & q.tx_irq_st)
    | (q.irq_en[IRQ_RX_FULL] & q.rx_irq_st);
endmodule : ssp_core

/* File: bench/ssp_asserts.sv */
// bus and pin assertions for the serial port, bound to its top module
`timescale 1ns/1ps
module ssp_asserts (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [ssp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ssp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic data_pin_oe_o
);
  import ssp_pkg::*;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_w_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_w_refuse: assert property (p_w_refuse) else $error("write taken early");
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_slverr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr == 6'h3C |=> s_axi_bresp == RESP_SLVERR; endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped write accepted");
  property p_clr_zero;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_IRQ_CLR |=> s_axi_rdata == 32'h0;
  endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("clear register readable");
  // the drive enable follows control writes only, never the link
  property p_oe_cause; $changed(data_pin_oe_o) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drive enable moved alone");
endmodule : ssp_asserts
bind ssp_core ssp_asserts u_chk (.*);

/* File: bench/ssp_master_model.sv */
// external synchronous master: drives the shift clock and serial data
`timescale 1ns/1ps
module ssp_master_model (
  output logic sck_o,
  output logic sdo_o,
  input wire logic sdi_i
);
  initial begin
    sck_o = 1'b0;
    sdo_o = 1'b0;
  end
  // clock idles low between frames; 800 ns period, lsb first
  task automatic xfer(input logic [8:0] tx, input int n, output logic [8:0] rx);
    rx = '0;
    #37;
    for (int i = 0; i < n; i++) begin
      sdo_o = tx[i];
      #400 sck_o = 1'b1;
      rx[i] = sdi_i;
      #400 sck_o = 1'b0;
    end
    // released line shows no stale bit
    sdo_o = ~sdo_o;
  endtask : xfer
endmodule : ssp_master_model

/* File: bench/sync_slave_serial_port_bench.sv */
// self-checking bench for the synchronous slave serial port
`timescale 1ns/1ps
module sync_slave_serial_port_bench;
  import ssp_pkg::*;
  logic ref_clk_i, rst_b_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, shift_clock_pin_i, data_pin_i, data_pin_o, data_pin_oe_o, irq_o;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int miscompares = 0;
  int checked = 0;
  ssp_core u_dut (.*);
  ssp_master_model u_mst (.sck_o(shift_clock_pin_i), .sdo_o(data_pin_i), .sdi_i(data_pin_o));
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic tmo(input int n);
    if (n >= 200) begin
      chk(32'h1, 32'h0);
      end_sim();
    end
  endtask : tmo
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 200);
    s_axi_bready <= 1'b0;
    tmo(n);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 200);
    s_axi_rready <= 1'b0;
    tmo(n);
    chk(s_axi_rdata & {24'hFFFFFF, m}, {24'h0, e});
  endtask : rd
  task automatic wirq(input logic e);
    int n;
    n = 0;
    while (irq_o !== e && n < 200) begin
      @(posedge ref_clk_i);
      n++;
    end
    tmo(n);
    chk({31'h0, irq_o}, {31'h0, e});
  endtask : wirq
  task automatic t_regs();
    rd(OFF_TX_CTRL, 8'hFF, TX_CTRL_RST);
    rd(OFF_RX_CTRL, 8'hFF, RX_CTRL_RST);
    rd(OFF_IRQ_CLR, 8'hFF, 8'h00);
    wr(6'h3C, 8'h55, RESP_SLVERR);
    wr(OFF_IRQ_STAT, 8'h03, RESP_SLVERR);
    wirq(1'b0);
  endtask : t_regs
  task automatic t_tx();
    logic [8:0] r;
    wr(OFF_RX_CTRL, 8'h80, RESP_OKAY);
    wr(OFF_TX_CTRL, 8'h51, RESP_OKAY);
    wr(OFF_IRQ_EN, 8'h01, RESP_OKAY);
    wr(OFF_TX_HOLD, 8'hA5, RESP_OKAY);
    wr(OFF_TX_CTRL, 8'h71, RESP_OKAY);
    rd(OFF_IRQ_STAT, 8'hFF, 8'h01);
    wr(OFF_TX_HOLD, 8'h3C, RESP_OKAY);
    rd(OFF_IRQ_STAT, 8'hFF, 8'h00);
    wirq(1'b0);
    chk({31'h0, data_pin_oe_o}, 32'h1);
    u_mst.xfer(9'h000, 9, r);
    chk({23'h0, r}, 32'h1A5);
    wirq(1'b1);
    rd(OFF_IRQ_STAT, 8'hFF, 8'h01);
    u_mst.xfer(9'h000, 9, r);
    chk({23'h0, r}, 32'h13C);
    wr(OFF_IRQ_EN, 8'h00, RESP_OKAY);
    wirq(1'b0);
    rd(OFF_IRQ_STAT, 8'h01, 8'h01);
    wr(OFF_IRQ_CLR, 8'h01, RESP_OKAY);
    rd(OFF_IRQ_STAT, 8'h01, 8'h00);
    wr(OFF_TX_CTRL, 8'h51, RESP_OKAY);
    rd(OFF_TX_CTRL, 8'hFD, 8'h51);
    chk({31'h0, data_pin_oe_o}, 32'h0);
    wr(OFF_TX_CTRL, 8'hF1, RESP_OKAY);
    chk({31'h0, data_pin_oe_o}, 32'h0);
    wr(OFF_TX_CTRL, 8'h51, RESP_OKAY);
  endtask : t_tx
  task automatic t_rx();
    logic [8:0] r;
    wr(OFF_RX_CTRL, 8'hF0, RESP_OKAY);
    wr(OFF_IRQ_EN, 8'h02, RESP_OKAY);
    u_mst.xfer(9'h15A, 9, r);
    wirq(1'b1);
    rd(OFF_RX_CTRL, 8'hFF, 8'hF1);
    rd(OFF_RX_BUF, 8'hFF, 8'h5A);
    wirq(1'b0);
    // single receive off: reception must carry on regardless
    wr(OFF_RX_CTRL, 8'hD0, RESP_OKAY);
    u_mst.xfer(9'h0C3, 9, r);
    u_mst.xfer(9'h0C3, 9, r);
    rd(OFF_RX_CTRL, 8'h02, 8'h02);
    rd(OFF_RX_BUF, 8'hFF, 8'hC3);
    wr(OFF_RX_CTRL, 8'hC0, RESP_OKAY);
    rd(OFF_RX_CTRL, 8'h02, 8'h00);
    wr(OFF_RX_CTRL, 8'hD0, RESP_OKAY);
    u_mst.xfer(9'h1FF, 4, r);
    wr(OFF_RX_CTRL, 8'hC0, RESP_OKAY);
    wr(OFF_RX_CTRL, 8'hD0, RESP_OKAY);
    u_mst.xfer(9'h196, 9, r);
    rd(OFF_RX_CTRL, 8'h03, 8'h01);
    rd(OFF_RX_BUF, 8'hFF, 8'h96);
  endtask : t_rx
  initial begin
    rst_b_i = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    end_sim();
  end
endmodule : sync_slave_serial_port_bench
